// ### hdl/mrh_pkg.sv
// Purpose: Shared types and constants for the run/halt group sync block
// Assumes: One card clock at 125 MHz; commands arrive as one-cycle pulses
// Notes:   Mode and status encodings are local to this block
package mrh_pkg;
  // ==========================================================
  // Mode and status enumerations
  typedef enum logic [1:0] {MRH_IND, MRH_MASTER, MRH_SLAVE, MRH_RSVD} mrh_mode_t;
  typedef enum logic [2:0] {
    MRH_ST_READY, MRH_ST_WAIT_RUN, MRH_ST_RUNNING, MRH_ST_FINISH,
    MRH_ST_RUN_DONE, MRH_ST_WAIT_OUT
  } mrh_state_t;
  // ==========================================================
  // Command pulse bundle
  typedef struct packed {
    logic run;          // Run addressed to this unit
    logic group_run;    // group_run_cmd
    logic total_run;    // total_run_cmd
    logic group_halt;   // group_halt_cmd
    logic total_halt;   // total_halt_cmd
    logic local_halt;   // Own halt: breakpoint, error, trace full, key
    logic fault_halt;   // Halt raised by breakpoint or error
  } mrh_cmd_t;
  // ==========================================================
  // Constants
  localparam logic       MRH_SYNC_ON   = 1'b1;
  localparam logic       MRH_SYNC_RST  = 1'b0;
  localparam logic [1:0] MRH_SYNC_INIT = 2'h3;
  localparam int         MRH_SYNC_LAT  = 3;
endpackage : mrh_pkg

// ### hdl/mrh_sync.sv
// Purpose: Run/halt line group start and halt coordination for one card
// Assumes: Shared wired-AND line; last card fits the pull-up outside
// Notes:   Command in progress is finished when cmd_busy falls
//
// Contract
// - Slave forces start-synchronous flag to one
// - Open-collector drive: pull low or release
// - Driver enabled only for master or slave
// - Monitor on for slave or sync flag
// - Slave halts on own causes and line
// - Run commands release driver; synced units start when high
// - Synced independent waits for high line
// - Plain independent starts now; ignores group run
// - Unsynced master starts immediately on runs
// - Halted master or slave pulls line low
// - Slave finishes current command, then halts
// - Fault halts leave masters, independents running
// - Group halt stops masters, not independents
// - Total halt stops every unit
// - Record line high at stop: first stopper
// - Master or slave config pulls line low
// - Synced run command enters waiting-to-run state
// - Slave arms halt only after running
// - Running independent ignores low line
// - First stopper reports run complete, autopoll
// - Late stopper reports waiting to output
// - Global reset option drives shared reset
`timescale 1ns/10ps
module mrh_sync
  import mrh_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Configuration from mp_mode_config_cmd
  input  wire logic       mp_mode_config_cmd,
  input  wire mrh_mode_t  cfg_mode,
  input  wire logic       cfg_sync,
  input  wire logic       autopoll_en,
  input  wire logic       global_reset_sel,
  input  wire logic       foreground,
  // Commands and halt causes
  input  wire mrh_cmd_t   cmd,
  input  wire logic       cmd_busy,
  // Run/halt line pin
  input  wire logic       rh_in,
  output logic            rh_out,
  output logic            rh_oe,
  // Shared reset line pin
  input  wire logic       greset_in,
  output logic            greset_out,
  output logic            greset_oe,
  // Status
  output logic            run_en,
  output mrh_state_t      status,
  output logic            first_stop,
  output logic            autopoll_req,
  output logic            mp_active,
  output logic            sync_flag,
  output logic            drv_en,
  output logic            mon_en,
  output logic            unit_reset
);
  // ==========================================================
  // Line synchroniser
  logic       rh_meta;     // First stage, read only by rh_sync
  logic       rh_sync;     // Usable line level
  logic       rh_prev;     // Delayed copy for edge detect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rh_meta <= MRH_SYNC_INIT[0];
      rh_sync <= MRH_SYNC_INIT[1];
      rh_prev <= MRH_SYNC_INIT[1];
    end else begin
      rh_meta <= rh_in;
      rh_sync <= rh_meta;
      rh_prev <= rh_sync;
    end
  end
  wire rh_fall = rh_prev & ~rh_sync;
  // ==========================================================
  // Configuration state
  mrh_mode_t  mode;        // Current processor mode
  logic       sync_raw;    // Separately written flag
  logic       mp_on;       // Multiprocessing mode active
  mrh_mode_t  next_mode;
  logic       next_sync_raw;
  logic       next_mp_on;
  // Shared reset pulse also clears mp mode, under the global option only
  wire        greset_hit = global_reset_sel & greset_in;
  always_comb begin
    next_mode     = mode;
    next_sync_raw = sync_raw;
    next_mp_on    = mp_on;
    if (greset_hit) begin
      next_mode     = MRH_IND;
      next_sync_raw = MRH_SYNC_RST;
      next_mp_on    = 1'b0;
    end else if (mp_mode_config_cmd) begin
      // Reserved code falls back to independent
      next_mode     = (cfg_mode == MRH_RSVD) ? MRH_IND : cfg_mode;
      next_sync_raw = cfg_sync;
      next_mp_on    = 1'b1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode     <= MRH_IND;
      sync_raw <= MRH_SYNC_RST;
      mp_on    <= 1'b0;
    end else begin
      mode     <= next_mode;
      sync_raw <= next_sync_raw;
      mp_on    <= next_mp_on;
    end
  end
  // Derived configuration
  wire is_slave  = (mode == MRH_SLAVE);
  wire is_master = (mode == MRH_MASTER);
  wire is_ind    = (mode == MRH_IND);
  assign sync_flag = is_slave ? MRH_SYNC_ON : sync_raw;
  assign drv_en    = is_master | is_slave;
  assign mon_en    = is_slave | sync_flag;
  // ==========================================================
  // Run/halt state machine
  mrh_state_t state;
  logic       pull;        // Driver pulling line low
  logic       armed;       // Slave halt mechanism armed
  logic       first;       // Stopped with line high
  logic       poll;        // Autopoll request
  mrh_state_t next_state;
  logic       next_pull;
  logic       next_armed;
  logic       next_first;
  logic       next_poll;
  logic       any_run;
  logic       do_run;
  logic       halt_req;
  logic       line_halt;
  always_comb begin
    // Which run commands this unit accepts
    any_run = cmd.run | cmd.total_run | cmd.group_run;
    do_run  = (is_ind & ~sync_flag) ? (cmd.run | cmd.total_run) : any_run;
    // Halts: masters ignore line; independents ignore line and group halt
    line_halt = is_slave & armed & rh_fall & ~cmd.fault_halt;
    halt_req  = cmd.local_halt | cmd.total_halt
              | (cmd.group_halt & ~is_ind);
    next_state = state;
    next_pull  = pull;
    next_armed = armed;
    next_first = first;
    next_poll  = 1'b0;
    if (greset_hit) begin
      next_state = MRH_ST_READY;
      next_pull  = 1'b0;
      next_armed = 1'b0;
    end else if (mp_mode_config_cmd) begin
      next_state = MRH_ST_READY;
      next_pull  = (cfg_mode == MRH_MASTER) | (cfg_mode == MRH_SLAVE);
      next_armed = 1'b0;
    end else begin
      case (state)
        MRH_ST_READY, MRH_ST_RUN_DONE, MRH_ST_WAIT_OUT: begin
          if (state == MRH_ST_WAIT_OUT && foreground) begin
            next_state = MRH_ST_READY;
          end
          if (do_run) begin
            next_pull  = 1'b0;
            next_state = MRH_ST_WAIT_RUN;
            // Unsynced master or independent start at once
            if (~sync_flag) begin
              next_state = MRH_ST_RUNNING;
              next_armed = is_slave;
            end
          end
        end
        MRH_ST_WAIT_RUN: begin
          if (halt_req) begin
            next_state = MRH_ST_READY;
            next_pull  = drv_en;
          end else if (rh_sync) begin
            next_state = MRH_ST_RUNNING;
            next_armed = is_slave;
          end
        end
        MRH_ST_RUNNING: begin
          if (halt_req) begin
            next_state = MRH_ST_FINISH;
          end else if (line_halt) begin
            next_state = MRH_ST_FINISH;
          end
        end
        MRH_ST_FINISH: begin
          // Current command completes before the stop lands
          if (~cmd_busy) begin
            next_pull  = drv_en;
            next_armed = 1'b0;
            next_first = rh_sync;
            if (rh_sync) begin
              next_state = MRH_ST_RUN_DONE;
              next_poll  = autopoll_en;
            end else begin
              next_state = MRH_ST_WAIT_OUT;
            end
          end
        end
        default: next_state = MRH_ST_READY;
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= MRH_ST_READY;
      pull  <= 1'b0;
      armed <= 1'b0;
      first <= 1'b0;
      poll  <= 1'b0;
    end else begin
      state <= next_state;
      pull  <= next_pull;
      armed <= next_armed;
      first <= next_first;
      poll  <= next_poll;
    end
  end
  // ==========================================================
  // Outputs
  // Open collector: data is always low, only the enable moves
  assign rh_out       = 1'b0;
  assign rh_oe        = pull & drv_en;
  assign run_en       = (state == MRH_ST_RUNNING) | (state == MRH_ST_FINISH);
  assign status       = state;
  assign first_stop   = first;
  assign autopoll_req = poll;
  assign mp_active    = mp_on;
  // Local reset stays local; global one pulls the shared line
  assign greset_out   = 1'b0;
  assign greset_oe    = global_reset_sel & rst;
  assign unit_reset   = rst | greset_hit;
  // ==========================================================
  // Checks
  property p_ind_never_drives;
    @(posedge clk) disable iff (rst) is_ind |-> !rh_oe;
  endproperty
  a_ind_never_drives: assert property (p_ind_never_drives)
    else $error("independent unit drives line");
  property p_slave_sync;
    @(posedge clk) disable iff (rst) is_slave |-> sync_flag && mon_en;
  endproperty
  a_slave_sync: assert property (p_slave_sync)
    else $error("slave without sync flag");
  property p_cfg_pull;
    @(posedge clk) disable iff (rst)
      (mp_mode_config_cmd && !greset_hit && (cfg_mode == MRH_MASTER || cfg_mode == MRH_SLAVE))
      |=> rh_oe;
  endproperty
  a_cfg_pull: assert property (p_cfg_pull)
    else $error("config did not pull line");
  property p_run_release;
    @(posedge clk) disable iff (rst)
      (state == MRH_ST_READY && do_run && !mp_mode_config_cmd && !greset_hit) |=> !rh_oe;
  endproperty
  a_run_release: assert property (p_run_release)
    else $error("run did not release line");
  property p_wait_low;
    @(posedge clk) disable iff (rst)
      (state == MRH_ST_WAIT_RUN && !rh_sync && !mp_mode_config_cmd && !greset_hit)
      |=> !run_en;
  endproperty
  a_wait_low: assert property (p_wait_low)
    else $error("started with line low");
  property p_ind_line;
    @(posedge clk) disable iff (rst)
      (is_ind && state == MRH_ST_RUNNING && !halt_req && !mp_mode_config_cmd
       && !greset_hit) |=> state == MRH_ST_RUNNING;
  endproperty
  a_ind_line: assert property (p_ind_line)
    else $error("independent stopped without request");
  property p_halt_pull;
    @(posedge clk) disable iff (rst)
      (state == MRH_ST_FINISH && !cmd_busy && drv_en && !mp_mode_config_cmd
       && !greset_hit) |=> rh_oe;
  endproperty
  a_halt_pull: assert property (p_halt_pull)
    else $error("halted unit left line released");
  property p_first;
    @(posedge clk) disable iff (rst)
      (state == MRH_ST_FINISH && !cmd_busy && !mp_mode_config_cmd && !greset_hit)
      |=> first_stop == $past(rh_sync);
  endproperty
  a_first: assert property (p_first)
    else $error("first stop flag wrong");
  property p_busy_hold;
    @(posedge clk) disable iff (rst)
      (state == MRH_ST_FINISH && cmd_busy && !mp_mode_config_cmd && !greset_hit)
      |=> state == MRH_ST_FINISH;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("halted before command finished");
endmodule : mrh_sync

// ### tb/mrh_line_model.sv
// Purpose: Wired-AND run/halt line as the other cards in the chain see it
// Assumes: Pull-up on the last card; every card pulls low or releases
// Notes:   peer_pull stands for all the other master and slave cards
`timescale 1ns/10ps
module mrh_line_model (
  // Pull requests from this card and the other cards
  input  wire logic dut_pull,   // This card's open-collector enable
  input  wire logic peer_pull,  // Any other card holding the line low
  // Resolved line level
  output logic      line        // High only when nobody pulls
);
  // ============================================================
  // Line resolution
  // No driver ever pushes high, so the pull-up decides a released line
  assign line = ~(dut_pull | peer_pull);
endmodule : mrh_line_model

// ### tb/tb.sv
// Purpose: Self-checking bench for the run/halt group sync block
// Assumes: Inputs change on the falling edge; commands are one-cycle pulses
// Notes:   Each scenario starts from a fresh reset to keep them independent
`timescale 1ns/10ps
module tb;
  import mrh_pkg::*;
  // ============================================================
  // Stimulus and observed signals
  logic       clk = 1'b0;          // Card clock
  logic       rst = 1'b1;          // Async reset
  logic       cfg_pulse = 1'b0;    // mp_mode_config_cmd
  mrh_mode_t  mode = MRH_IND;      // Mode to load
  logic       sync = 1'b0;         // Start-synchronous flag to load
  logic       apoll = 1'b0;        // Autopoll enable
  logic       gsel = 1'b0;         // Global reset option
  logic       fg = 1'b0;           // Foreground
  mrh_cmd_t   cmd = '0;            // Command pulses
  logic       busy = 1'b0;         // Command in progress
  logic       peer = 1'b1;         // Other cards hold the line low
  logic       line;                // Resolved line
  logic       greset = 1'b0;       // Shared reset line from other cards
  logic       rh_oe, greset_oe, run_en, first_stop, sync_flag, drv_en, mon_en;
  logic       rh_out, greset_out, autopoll_req, mp_active, unit_reset;
  mrh_state_t status;
  int         n_fail = 0;
  int         checked = 0;
  always #4 clk = ~clk;
  // ============================================================
  // Design and line partner
  mrh_sync mrh_sync_inst (
    .clk(clk), .rst(rst), .mp_mode_config_cmd(cfg_pulse), .cfg_mode(mode),
    .cfg_sync(sync), .autopoll_en(apoll), .global_reset_sel(gsel),
    .foreground(fg), .cmd(cmd), .cmd_busy(busy), .rh_in(line), .rh_out(rh_out),
    .rh_oe(rh_oe), .greset_in(greset), .greset_out(greset_out), .greset_oe(greset_oe),
    .run_en(run_en), .status(status), .first_stop(first_stop),
    .autopoll_req(autopoll_req), .mp_active(mp_active), .sync_flag(sync_flag),
    .drv_en(drv_en), .mon_en(mon_en), .unit_reset(unit_reset)
  );
  mrh_line_model mrh_line_model_inst (.dut_pull(rh_oe), .peer_pull(peer), .line(line));
  // ============================================================
  // Shared tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic do_reset();
    @(negedge clk) rst = 1'b1;
    peer  = 1'b1;
    busy  = 1'b0;
    fg    = 1'b0;
    apoll = 1'b0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
  endtask : do_reset
  // One-cycle command pulse; a cycle of quiet follows so back-to-back calls never
  // lower and raise the bundle in one time step
  task automatic send(input logic [6:0] c);
    @(negedge clk) cmd = mrh_cmd_t'(c);
    @(negedge clk) cmd = '0;
  endtask : send
  task automatic config_unit(input mrh_mode_t m, input logic s);
    mode = m;
    sync = s;
    cfg_pulse = 1'b1;
    @(negedge clk) cfg_pulse = 1'b0;
  endtask : config_unit
  // Bounded wait: line goes through the synchroniser first
  task automatic wait_st(input mrh_state_t exp);
    for (int i = 0; i < 12 && status !== exp; i++) @(negedge clk);
    check("status", status, exp);
  endtask : wait_st
  // ============================================================
  // Scenarios
  task automatic t_slave();
    do_reset();
    config_unit(MRH_SLAVE, 1'b0);
    check("sync_flag", sync_flag, 8'h01);
    check("drv_en", drv_en, 8'h01);
    check("mon_en", mon_en, 8'h01);
    check("rh_oe", rh_oe, 8'h01);
    check("rh_out", rh_out, 8'h00);
    check("mp_active", mp_active, 8'h01);
    send(7'h40);
    check("status", status, MRH_ST_WAIT_RUN);
    check("rh_oe", rh_oe, 8'h00);
    repeat (5) @(negedge clk);
    check("status", status, MRH_ST_WAIT_RUN);
    peer = 1'b0;
    wait_st(MRH_ST_RUNNING);
    // Line falls while a command is still in progress
    peer = 1'b1;
    busy = 1'b1;
    wait_st(MRH_ST_FINISH);
    repeat (3) @(negedge clk);
    check("status", status, MRH_ST_FINISH);
    check("run_en", run_en, 8'h01);
    busy = 1'b0;
    wait_st(MRH_ST_WAIT_OUT);
    check("rh_oe", rh_oe, 8'h01);
    check("first_stop", first_stop, 8'h00);
    repeat (3) @(negedge clk);
    check("status", status, MRH_ST_WAIT_OUT);
    fg = 1'b1;
    @(negedge clk) fg = 1'b0;
    check("status", status, MRH_ST_READY);
  endtask : t_slave
  task automatic t_indep();
    do_reset();
    config_unit(MRH_IND, 1'b0);
    check("drv_en", drv_en, 8'h00);
    check("mon_en", mon_en, 8'h00);
    peer = 1'b0;
    send(7'h20);
    check("status", status, MRH_ST_READY);
    send(7'h40);
    check("status", status, MRH_ST_RUNNING);
    // Line falls while running: must be ignored
    peer = 1'b1;
    repeat (6) @(negedge clk);
    check("run_en", run_en, 8'h01);
    send(7'h08);
    check("run_en", run_en, 8'h01);
    send(7'h04);
    repeat (2) @(negedge clk);
    check("run_en", run_en, 8'h00);
    check("rh_oe", rh_oe, 8'h00);
    send(7'h10);
    check("status", status, MRH_ST_RUNNING);
  endtask : t_indep
  task automatic t_master();
    do_reset();
    apoll = 1'b1;
    config_unit(MRH_MASTER, 1'b0);
    check("mon_en", mon_en, 8'h00);
    check("rh_oe", rh_oe, 8'h01);
    send(7'h20);
    check("status", status, MRH_ST_RUNNING);
    // Line rises then falls under a running master
    peer = 1'b0;
    repeat (4) @(negedge clk);
    peer = 1'b1;
    repeat (4) @(negedge clk);
    check("status", status, MRH_ST_RUNNING);
    peer = 1'b0;
    repeat (4) @(negedge clk);
    send(7'h03);
    wait_st(MRH_ST_RUN_DONE);
    check("autopoll_req", autopoll_req, 8'h01);
    check("first_stop", first_stop, 8'h01);
    check("rh_oe", rh_oe, 8'h01);
    @(negedge clk);
    check("autopoll_req", autopoll_req, 8'h00);
  endtask : t_master
  task automatic t_master_sync();
    do_reset();
    // Reset of an idle unit: shared line follows only under the global option
    gsel = 1'b1;
    @(negedge clk) rst = 1'b1;
    @(negedge clk);
    check("greset_oe", greset_oe, 8'h01);
    gsel = 1'b0;
    @(negedge clk);
    check("greset_oe", greset_oe, 8'h00);
    check("greset_out", greset_out, 8'h00);
    do_reset();
    config_unit(MRH_MASTER, 1'b1);
    check("mon_en", mon_en, 8'h01);
    send(7'h10);
    check("status", status, MRH_ST_WAIT_RUN);
    peer = 1'b0;
    wait_st(MRH_ST_RUNNING);
    send(7'h08);
    wait_st(MRH_ST_RUN_DONE);
    // Synchronous independent waits on a low line
    config_unit(MRH_IND, 1'b1);
    check("rh_oe", rh_oe, 8'h00);
    peer = 1'b1;
    send(7'h20);
    repeat (4) @(negedge clk);
    check("status", status, MRH_ST_WAIT_RUN);
    peer = 1'b0;
    wait_st(MRH_ST_RUNNING);
    // Shared reset pulse under the global option
    gsel   = 1'b1;
    greset = 1'b1;
    #1 check("unit_reset", unit_reset, 8'h01);
    @(negedge clk) greset = 1'b0;
    check("mp_active", mp_active, 8'h00);
    check("run_en", run_en, 8'h00);
    // Same pulse under the local option leaves the unit alone
    gsel = 1'b0;
    config_unit(MRH_MASTER, 1'b0);
    greset = 1'b1;
    #1 check("unit_reset", unit_reset, 8'h00);
    @(negedge clk) greset = 1'b0;
    check("mp_active", mp_active, 8'h01);
  endtask : t_master_sync
  // ============================================================
  // Verdict
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  initial begin
    t_slave();
    t_indep();
    t_master();
    t_master_sync();
    close_out();
  end
  // Watchdog: whole run is little more than a hundred cycles
  initial begin
    #20000;
    n_fail++;
    close_out();
  end
endmodule : tb
